// File: bench/sed_link_props.sv
// link checker for the eeprom erase and power-down ends
`timescale 1ns/100ps
`default_nettype none
module sed_link_props #(
	parameter int ERASE_CYCLES = 400,
	parameter int DP_CYCLES = 3
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic csN,
	input wire logic sck,
	input wire logic si,
	input wire logic soOe,
	input wire logic writeInProgress,
	input wire logic writeEnableLatch,
	input wire logic deepPowerDown
);
	// ****
	// erase length counter
	// ****
	logic [15:0] wipCnt_q;
	logic [15:0] wipCnt_d;
	assign wipCnt_d = writeInProgress ? wipCnt_q + 16'h1 : 16'h0;
	always_ff @(posedge sys_clk) begin
		wipCnt_q <= rstn ? wipCnt_d : 16'h0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ****
	// properties
	// ****
	// slack of six cycles covers the select synchroniser
	a_so_idle_deselect: assert property (csN [*6] |-> !soOe)
		else $error("serial output driven while deselected");
	a_so_quiet_erase: assert property (writeInProgress |-> !soOe)
		else $error("serial output driven during erase");
	a_wip_needs_latch: assert property ($rose(writeInProgress) |-> $past(writeEnableLatch, 3))
		else $error("erase started without latch");
	a_wip_after_select: assert property ($rose(writeInProgress) |-> csN && $past(csN, 2))
		else $error("erase started before select rose");
	a_wip_holds: assert property ($rose(writeInProgress) |-> writeInProgress [*8])
		else $error("busy flag dropped early");
	a_wip_bounded: assert property (wipCnt_q <= 16'(ERASE_CYCLES + 2))
		else $error("erase runs too long");
	a_wip_full_time: assert property ($fell(writeInProgress) |->
		$past(wipCnt_q) + 16'h2 >= 16'(ERASE_CYCLES))
		else $error("erase ended too soon");
	a_pd_entry_delay: assert property ($rose(deepPowerDown) |->
		$past(csN, DP_CYCLES) && !writeInProgress)
		else $error("power-down reached too early");
	a_pd_no_erase: assert property (deepPowerDown |->
		!writeInProgress && !$rose(writeEnableLatch))
		else $error("command acted in power-down");
	a_sck_idle_low: assert property (csN |-> !sck)
		else $error("serial clock high while deselected");
	a_si_steady_high: assert property (!csN && sck && $past(sck) |-> $stable(si))
		else $error("data changed while clock high");
	c_erase: cover property ($rose(writeInProgress));
	c_pd: cover property ($rose(deepPowerDown));
	c_release: cover property ($fell(deepPowerDown));
	c_sig: cover property ($rose(soOe));
endmodule // sed_link_props
`default_nettype wire

// File: bench/spi_eeprom_erase_powerdown_tb.sv
// bench joining host and eeprom ends, apb stimulus against an array model
`timescale 1ns/100ps
`default_nettype none
`include "sed_params.svh"
module spi_eeprom_erase_powerdown_tb;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, hostBusy;
	logic [1:0] blockProtect = 2'h0;
	logic ldEn = 1'b0;
	logic [5:0] ldAddr = 6'h00;
	logic [5:0] rdAddr = 6'h00;
	logic [7:0] ldData = 8'h00;
	logic [7:0] rdData;
	logic writeInProgress, writeEnableLatch, deepPowerDown;
	int fail_count = 0;
	int compares = 0;
	logic [7:0] mem [64];
	logic wel = 1'b0;
	logic pd = 1'b0;
	logic [31:0] rd;
	logic er;
	always #50 sys_clk = ~sys_clk;
	sed_link_if link ();
	sed_host #(.SCK_HALF(4)) i_sed_host (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hostBusy(hostBusy));
	sed_device #(.ERASE_CYCLES(400), .DP_CYCLES(3), .REL_CYCLES(3)) i_sed_device (
		.sys_clk(sys_clk), .rstn(rstn), .link(link), .blockProtect(blockProtect),
		.ldEn(ldEn), .ldAddr(ldAddr), .ldData(ldData), .rdAddr(rdAddr), .rdData(rdData),
		.writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
		.deepPowerDown(deepPowerDown));
	sed_link_props i_sed_link_props (.sys_clk(sys_clk),
		.rstn(rstn), .csN(link.csN), .sck(link.sck), .si(link.si), .soOe(link.soOe),
		.writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
		.deepPowerDown(deepPowerDown));
	// ****
	// shared tasks
	// ****
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [23:0] sa(input logic [1:0] s);
		return {8'h00, 10'($urandom), s, 4'($urandom)};
	endfunction
	task model(input logic [7:0] o, input int ab, input logic [5:0] a);
		logic pr;
		pr = blockProtect == 2'h3 || (blockProtect == 2'h1 && a[5:4] == 2'h3)
			|| (blockProtect == 2'h2 && a[5]);
		if (!pd && o == `SED_OPC_WRITE_ENABLE_COMMAND && ab == 0) wel = 1'b1;
		if (!pd && wel && o == `SED_OPC_SECTOR_ERASE && ab == `SED_ADDR_BYTES && !pr) begin
			wel = 1'b0;
			for (int i = 0; i < 16; i++) mem[{a[5:4], 4'(i)}] = 8'hff;
		end
		if (!pd && wel && o == `SED_OPC_CHIP_ERASE && ab == 0 && blockProtect == 2'h0) begin
			wel = 1'b0;
			for (int i = 0; i < 64; i++) mem[i] = 8'hff;
		end
		if (o == `SED_OPC_POWER_DOWN && ab == 0) pd = 1'b1;
		if (o == `SED_OPC_RELEASE_SIG) pd = 1'b0;
	endtask
	task cmd(input logic [7:0] o, input int ab, input int rb, input logic [23:0] a,
		input logic wt);
		apb(1'b1, `SED_REG_ADDR, {8'h00, a});
		apb(1'b1, `SED_REG_CMD, {19'h0, rb[2:0], ab[1:0], o});
		@(posedge sys_clk);
		chk(hostBusy, 1'b1);
		do begin
			apb(1'b0, `SED_REG_STATUS, 32'h0);
		end while (rd[0] !== 1'b0);
		// decode and entry delay land behind the host's trailing gap
		repeat (10) @(posedge sys_clk);
		while (wt && writeInProgress !== 1'b0) begin
			@(posedge sys_clk);
		end
		// model sees every byte after the opcode, as the device counts them
		model(o, ab + rb, a[5:0]);
		chk(deepPowerDown, pd);
	endtask
	task load;
		logic [7:0] d;
		for (int i = 0; i < 64; i++) begin
			d = 8'($urandom);
			@(posedge sys_clk);
			ldEn <= 1'b1;
			ldAddr <= 6'(i);
			ldData <= d;
			mem[i] = d;
		end
		@(posedge sys_clk);
		ldEn <= 1'b0;
	endtask
	task memchk;
		for (int i = 0; i < 64; i++) begin
			@(posedge sys_clk);
			rdAddr <= 6'(i);
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk(rdData, mem[i]);
		end
	endtask
	// ****
	// watchdog
	// ****
	initial begin
		repeat (80000) @(posedge sys_clk);
		fail_count++;
		results();
	end
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(47333));
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		load();
		cmd(`SED_OPC_SECTOR_ERASE, 2, 0, sa(2'h0), 1'b1);
		memchk();
		cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
		chk(writeEnableLatch, wel);
		cmd(`SED_OPC_SECTOR_ERASE, 2, 1, sa(2'h3), 1'b1);
		cmd(`SED_OPC_SECTOR_ERASE, 2, 0, sa(2'h1), 1'b0);
		chk(writeInProgress, 1'b1);
		cmd(`SED_OPC_RELEASE_SIG, 2, 1, 24'h0, 1'b1);
		apb(1'b0, `SED_REG_RXDATA, 32'h0);
		chk(rd[7:0], 8'hff);
		memchk();
		for (int b = 3; b > 0; b--) begin
			@(posedge sys_clk);
			blockProtect <= 2'(b);
			for (int s = 0; s < 4; s++) begin
				cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
				cmd(`SED_OPC_SECTOR_ERASE, 2, 0, sa(2'(s)), 1'b1);
			end
			memchk();
		end
		load();
		cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_CHIP_ERASE, 0, 0, 24'h0, 1'b1);
		blockProtect <= 2'h0;
		cmd(`SED_OPC_CHIP_ERASE, 1, 0, 24'h0, 1'b1);
		memchk();
		cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_CHIP_ERASE, 0, 0, 24'h0, 1'b1);
		memchk();
		cmd(`SED_OPC_RELEASE_SIG, 2, 2, sa(2'h2), 1'b1);
		apb(1'b0, `SED_REG_RXDATA, 32'h0);
		chk(rd[15:0], {2{`SED_SIGNATURE}});
		cmd(`SED_OPC_POWER_DOWN, 1, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_POWER_DOWN, 0, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
		chk(writeEnableLatch, wel);
		cmd(`SED_OPC_RELEASE_SIG, 2, 1, sa(2'h3), 1'b1);
		apb(1'b0, `SED_REG_RXDATA, 32'h0);
		chk(rd[7:0], `SED_SIGNATURE);
		cmd(`SED_OPC_POWER_DOWN, 0, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_RELEASE_SIG, 0, 0, 24'h0, 1'b1);
		cmd(`SED_OPC_WRITE_ENABLE_COMMAND, 0, 0, 24'h0, 1'b1);
		chk(writeEnableLatch, wel);
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		results();
	end
endmodule // spi_eeprom_erase_powerdown_tb
`default_nettype wire

// File: core/sed_device.sv
// eeprom end: erase, deep power-down and signature commands
// Function
// - write enable command sets the latch
// - sector erase: opcode plus address bytes
// - select rise after address starts erase
// - sector erase fills sector with ones
// - busy flag set during any erase
// - protected sector erase aborts untouched
// - chip erase fills array with ones
// - select rise after opcode starts chip erase
// - chip erase ignored if any protection
// - power-down only on eight-bit framing
// - power-down settles after entry delay
// - power-down ignores all but release command
// - release command, dummy address, then signature
// - signature repeats while clocking continues
// - select rise leaves power-down after delay
// - early select rise still releases
// - no signature while erase in progress
// - protect codes: none, quarter, half, all
// - busy flag one when active, read-only
`timescale 1ns/100ps
`default_nettype none
`include "sed_params.svh"
module sed_device import sed_pkg::*; #(
	parameter int ADDR_BYTES = `SED_ADDR_BYTES,
	parameter int MEM_AW = 6,
	parameter int ERASE_CYCLES = `SED_ERASE_CYC,
	parameter int DP_CYCLES = `SED_DP_ENTRY_CYC,
	parameter int REL_CYCLES = `SED_REL_CYC,
	// arbitrary value
	parameter logic [7:0] SIGNATURE = `SED_SIGNATURE
) (
	input wire logic sys_clk,
	input wire logic rstn,
	sed_link_if.device link,
	input wire logic [1:0] blockProtect,
	input wire logic ldEn,
	input wire logic [MEM_AW-1:0] ldAddr,
	input wire logic [7:0] ldData,
	input wire logic [MEM_AW-1:0] rdAddr,
	output logic [7:0] rdData,
	output logic writeInProgress,
	output logic writeEnableLatch,
	output logic deepPowerDown
);
	localparam int AW = 8 * ADDR_BYTES;
	localparam logic [5:0] OPC_END = 6'(`SED_OPC_BITS);
	localparam logic [5:0] FRAME_END = 6'(`SED_OPC_BITS + AW);

	// true when the given 2-bit sector is write protected
	function automatic logic isProtected(input logic [1:0] bp, input logic [1:0] sector);
		logic prot;
		prot = 1'b1;
		unique case (bp)
			`SED_BP_NONE: prot = 1'b0;
			`SED_BP_QUARTER: prot = (sector == 2'h3);
			`SED_BP_HALF: prot = sector[1];
			default: prot = 1'b1;
		endcase
		return prot;
	endfunction

	// ****************************************************************
	// pin sampling
	// ****************************************************************
	logic [2:0] pinQ;
	logic [2:0] pinRise;
	logic [2:0] pinFall;
	sed_sync_edge #(.W(3), .INIT(3'h4)) u_pins (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d({link.csN, link.sck, link.si}),
		.q(pinQ),
		.rise(pinRise),
		.fall(pinFall)
	);
	wire logic csLow = ~pinQ[2];
	wire logic csRise = pinRise[2];
	wire logic csFall = pinFall[2];
	wire logic sckRise = pinRise[1];
	wire logic sckFall = pinFall[1];
	wire logic siQ = pinQ[0];

	// ****************************************************************
	// command shifter
	// ****************************************************************
	logic [5:0] bitCnt_q;
	logic [7:0] opc_q;
	logic [AW-1:0] addr_q;
	logic [2:0] outIdx_q;
	logic soBit_q;
	logic soOe_q;
	sed_mode_t mode_q;

	wire logic inOpcode = bitCnt_q < OPC_END;
	wire logic frameFull = bitCnt_q == FRAME_END;
	wire logic pastAddr = bitCnt_q >= FRAME_END;
	wire logic isRelease = opc_q == `SED_OPC_RELEASE_SIG;
	wire logic pdLike = (mode_q == MD_PD_ENTRY) || (mode_q == MD_POWER_DOWN);
	wire logic sigAllowed = (mode_q == MD_STANDBY) || pdLike;
	wire logic sigPhase = csLow && isRelease && pastAddr && sigAllowed;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bitCnt_q <= 6'h00;
			opc_q <= 8'h00;
			addr_q <= '0;
		end else if (csFall) begin
			bitCnt_q <= 6'h00;
		end else if (csLow && sckRise && (bitCnt_q != 6'h3f)) begin
			// counts on past the address, so trailing clocks void an erase
			bitCnt_q <= bitCnt_q + 6'h01;
			if (inOpcode) begin
				opc_q <= {opc_q[6:0], siQ};
			end else if (!pastAddr) begin
				addr_q <= {addr_q[AW-2:0], siQ};
			end
		end
	end

	// signature bits launched on falling clock, wrapping every eight
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			outIdx_q <= 3'h0;
			soBit_q <= 1'b0;
			soOe_q <= 1'b0;
		end else if (csFall || csRise) begin
			outIdx_q <= 3'h0;
			soOe_q <= 1'b0;
		end else if (sigPhase && sckFall) begin
			soBit_q <= SIGNATURE[3'h7 - outIdx_q];
			outIdx_q <= outIdx_q + 3'h1;
			soOe_q <= 1'b1;
		end
	end
	assign link.soOut = soBit_q;
	assign link.soOe = soOe_q;

	// ****************************************************************
	// command decode at select release
	// ****************************************************************
	logic wel_q;
	logic [31:0] timer_q;
	logic eraseAll_q;
	logic [1:0] sector_q;
	wire logic standby = mode_q == MD_STANDBY;
	wire logic opcOnly = csRise && (bitCnt_q == OPC_END);
	wire logic [1:0] addrSector = addr_q[MEM_AW-1 -: 2];
	wire logic wrenGo = opcOnly && standby && (opc_q == `SED_OPC_WRITE_ENABLE_COMMAND);
	wire logic ceGo = opcOnly && standby && wel_q && (opc_q == `SED_OPC_CHIP_ERASE)
		&& (blockProtect == `SED_BP_NONE);
	wire logic seGo = csRise && frameFull && standby && wel_q
		&& (opc_q == `SED_OPC_SECTOR_ERASE)
		&& !isProtected(blockProtect, addrSector);
	wire logic dpGo = opcOnly && standby && (opc_q == `SED_OPC_POWER_DOWN);
	wire logic relGo = csRise && pdLike && isRelease && !inOpcode;
	wire logic timerDone = timer_q == 32'h0000_0000;
	wire logic eraseDone = (mode_q == MD_ERASE) && timerDone;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mode_q <= MD_STANDBY;
			timer_q <= 32'h0000_0000;
			eraseAll_q <= 1'b0;
			sector_q <= 2'h0;
		end else begin
			if (!timerDone) begin
				timer_q <= timer_q - 32'h0000_0001;
			end
			unique case (mode_q)
				MD_STANDBY: begin
					if (ceGo || seGo) begin
						mode_q <= MD_ERASE;
						timer_q <= 32'(ERASE_CYCLES - 1);
						eraseAll_q <= ceGo;
						sector_q <= addrSector;
					end else if (dpGo) begin
						mode_q <= MD_PD_ENTRY;
						timer_q <= 32'(DP_CYCLES - 1);
					end
				end
				MD_ERASE: begin
					if (timerDone) begin
						mode_q <= MD_STANDBY;
					end
				end
				MD_PD_ENTRY, MD_POWER_DOWN: begin
					if (relGo) begin
						mode_q <= MD_RELEASE;
						timer_q <= 32'(REL_CYCLES - 1);
					end else if (mode_q == MD_PD_ENTRY && timerDone) begin
						mode_q <= MD_POWER_DOWN;
					end
				end
				MD_RELEASE: begin
					if (timerDone) begin
						mode_q <= MD_STANDBY;
					end
				end
				default: mode_q <= MD_STANDBY;
			endcase
		end
	end

	// latch consumed when an erase is launched
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wel_q <= 1'b0;
		end else if (ceGo || seGo) begin
			wel_q <= 1'b0;
		end else if (wrenGo) begin
			wel_q <= 1'b1;
		end
	end

	// ****************************************************************
	// array
	// ****************************************************************
	logic [7:0] mem_q [2**MEM_AW];
	always_ff @(posedge sys_clk) begin
		if (ldEn) begin
			mem_q[ldAddr] <= ldData;
		end
		if (eraseDone) begin
			for (int i = 0; i < 2**MEM_AW; i++) begin
				if (eraseAll_q || (2'(i >> (MEM_AW - 2)) == sector_q)) begin
					mem_q[i] <= 8'hff;
				end
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdData <= 8'h00;
		end else begin
			rdData <= mem_q[rdAddr];
		end
	end

	assign writeInProgress = mode_q == MD_ERASE;
	assign writeEnableLatch = wel_q;
	assign deepPowerDown = mode_q == MD_POWER_DOWN;
endmodule // sed_device
`default_nettype wire

// File: core/sed_host.sv
// host end: apb registers driving an spi master for the eeprom commands
`timescale 1ns/100ps
`default_nettype none
`include "sed_params.svh"
module sed_host import sed_pkg::*; #(
	parameter int SCK_HALF = `SED_SCK_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	sed_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic hostBusy
);
	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic [23:0] addr_q;
	logic [31:0] rx_q;
	sed_hstate_t st_q;
	wire logic busy = st_q != HS_IDLE;
	wire logic mapped = (paddr == `SED_REG_CMD) || (paddr == `SED_REG_ADDR)
		|| (paddr == `SED_REG_STATUS) || (paddr == `SED_REG_RXDATA);
	wire logic wrAcc = psel && penable && pwrite && mapped;
	// command writes while busy are dropped
	wire logic start = wrAcc && (paddr == `SED_REG_CMD) && !busy;
	wire logic [7:0] cmdOpc = pwdata[`SED_CMD_OPC_LSB +: 8];
	wire logic [1:0] cmdAbytes = pwdata[`SED_CMD_ABYTES_LSB +: 2];
	wire logic [2:0] cmdRbytes = pwdata[`SED_CMD_RBYTES_LSB +: 3];
	wire logic [31:0] rdMux = (paddr == `SED_REG_ADDR) ? {8'h00, addr_q}
		: (paddr == `SED_REG_STATUS) ? {31'h0000_0000, busy}
		: (paddr == `SED_REG_RXDATA) ? rx_q : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign hostBusy = busy;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			addr_q <= 24'h00_0000;
		end else begin
			if (psel && !penable) begin
				prdata <= rdMux;
			end
			if (wrAcc && (paddr == `SED_REG_ADDR)) begin
				addr_q <= pwdata[23:0];
			end
		end
	end

	// ****************************************************************
	// serial output sampling
	// ****************************************************************
	logic soQ;
	sed_sync_edge #(.W(1), .INIT(1'b1)) u_so (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d(link.soLine),
		.q(soQ),
		.rise(),
		.fall()
	);

	// ****************************************************************
	// spi master, mode 0, clock from divider
	// ****************************************************************
	logic [7:0] div_q;
	logic [6:0] bitsLeft_q;
	logic [31:0] tx_q;
	logic csN_q;
	logic sck_q;
	wire logic halfDone = div_q == 8'(SCK_HALF - 1);
	// address bytes pushed up against the opcode, unused upper bytes dropped
	wire logic [1:0] padBytes = 2'h3 - cmdAbytes;
	wire logic [23:0] addrTop = addr_q << {padBytes, 3'h0};
	wire logic [31:0] txLoad = {cmdOpc, addrTop};
	wire logic [6:0] bitsLoad = 7'(8 + 8 * int'(cmdAbytes) + 8 * int'(cmdRbytes));

	always_ff @(posedge sys_clk) begin
		if (!rstn || !busy || halfDone) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q <= HS_IDLE;
			csN_q <= 1'b1;
			sck_q <= 1'b0;
			tx_q <= 32'h0000_0000;
			rx_q <= 32'h0000_0000;
			bitsLeft_q <= 7'h00;
		end else begin
			unique case (st_q)
				HS_IDLE: begin
					if (start) begin
						st_q <= HS_LEAD;
						csN_q <= 1'b0;
						tx_q <= txLoad;
						bitsLeft_q <= bitsLoad;
					end
				end
				HS_LEAD, HS_LOW: begin
					if (halfDone) begin
						st_q <= HS_HIGH;
						sck_q <= 1'b1;
					end
				end
				HS_HIGH: begin
					if (halfDone) begin
						sck_q <= 1'b0;
						rx_q <= {rx_q[30:0], soQ};
						tx_q <= {tx_q[30:0], 1'b0};
						bitsLeft_q <= bitsLeft_q - 7'h01;
						st_q <= (bitsLeft_q == 7'h01) ? HS_TAIL : HS_LOW;
					end
				end
				HS_TAIL: begin
					if (halfDone) begin
						csN_q <= 1'b1;
						st_q <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (halfDone) begin
						st_q <= HS_IDLE;
					end
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end

	assign link.csN = csN_q;
	assign link.sck = sck_q;
	assign link.si = tx_q[31];
endmodule // sed_host
`default_nettype wire

// File: core/sed_sync_edge.sv
// two-stage synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module sed_sync_edge #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			meta_q <= INIT;
			sync_q <= INIT;
			prev_q <= INIT;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign q = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule // sed_sync_edge
`default_nettype wire

// File: inc/sed_link_if.sv
// spi link between host and eeprom
`timescale 1ns/100ps
`default_nettype none
interface sed_link_if;
	logic csN;
	logic sck;
	logic si;
	logic soOut;
	logic soOe;
	wire logic soLine;
	// ****************************************************************
	// serial output wire, pulled high while released
	// ****************************************************************
	assign soLine = soOe ? soOut : 1'b1;
	modport device (input csN, input sck, input si, output soOut, output soOe);
	modport host (output csN, output sck, output si, input soLine);
endinterface
`default_nettype wire

// File: inc/sed_params.svh
// constants of the serial eeprom erase and power-down logic and its host
`ifndef SED_PARAMS_SVH
`define SED_PARAMS_SVH
// ****************************************************************
// timing
// ****************************************************************
`define SED_CLK_NS 100
`define SED_ERASE_US 15000
`define SED_ERASE_CYC (`SED_ERASE_US * 1000 / `SED_CLK_NS)
`define SED_DP_ENTRY_NS 3000
`define SED_DP_ENTRY_CYC ((`SED_DP_ENTRY_NS + `SED_CLK_NS - 1) / `SED_CLK_NS)
`define SED_REL_NS 3000
`define SED_REL_CYC ((`SED_REL_NS + `SED_CLK_NS - 1) / `SED_CLK_NS)
`define SED_SCK_PERIOD_NS 800
`define SED_SCK_HALF_CYC (`SED_SCK_PERIOD_NS / `SED_CLK_NS / 2)
// ****************************************************************
// link commands
// ****************************************************************
`define SED_OPC_BITS 8
`define SED_OPC_WRITE_ENABLE_COMMAND 8'h06
`define SED_OPC_SECTOR_ERASE 8'hd8
`define SED_OPC_CHIP_ERASE 8'hc7
`define SED_OPC_POWER_DOWN 8'hb9
`define SED_OPC_RELEASE_SIG 8'hab
`define SED_ADDR_BYTES 2
`define SED_SIGNATURE 8'h5a
// ****************************************************************
// block protect codes
// ****************************************************************
`define SED_BP_NONE 2'h0
`define SED_BP_QUARTER 2'h1
`define SED_BP_HALF 2'h2
// ****************************************************************
// host registers
// ****************************************************************
`define SED_REG_CMD 8'h00
`define SED_REG_ADDR 8'h04
`define SED_REG_STATUS 8'h08
`define SED_REG_RXDATA 8'h0c
`define SED_CMD_OPC_LSB 0
`define SED_CMD_ABYTES_LSB 8
`define SED_CMD_RBYTES_LSB 10
`define SED_STAT_BUSY_BIT 0
`endif

// File: inc/sed_pkg.sv
// types shared by the eeprom device end and the host end
package sed_pkg;
	typedef enum logic [2:0] {
		MD_STANDBY = 3'b000,
		MD_ERASE = 3'b001,
		MD_PD_ENTRY = 3'b010,
		MD_POWER_DOWN = 3'b011,
		MD_RELEASE = 3'b100
	} sed_mode_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_LEAD = 3'b001,
		HS_HIGH = 3'b010,
		HS_LOW = 3'b011,
		HS_TAIL = 3'b100,
		HS_GAP = 3'b101
	} sed_hstate_t;
endpackage
